/* File: core/csb_map.svh */
`ifndef CSB_MAP_SVH
`define CSB_MAP_SVH

// register byte offsets
`define CSB_CFG_OFS       4'h0
`define CSB_RAM_INIT_OFS  4'h4
`define CSB_CTRL_OFS      4'h8
`define CSB_STATUS_OFS    4'hc

// cfg field positions (two storage elements, two line drivers)
`define CSB_CFG_INV_LSB   0
`define CSB_CFG_LATCH_LSB 2
`define CSB_CFG_SRVAL_LSB 4
`define CSB_CFG_GECON_LSB 6
`define CSB_CFG_SRCON_LSB 8
`define CSB_CFG_DRV0_LSB  10
`define CSB_CFG_DRV1_LSB  12
`define CSB_CFG_RESET     32'h0000_0000
`define CSB_CFG_MASK      32'h0000_3fff

// ctrl and status fields
`define CSB_CTRL_LOAD_BIT 0
`define CSB_STAT_Q_LSB    0
`define CSB_STAT_LINE_LSB 2

// reset values and responses
`define CSB_RAM_INIT_RESET 32'h0000_0000
`define CSB_RESP_OKAY     2'b00
`define CSB_RESP_SLVERR   2'b10

`endif

/* File: core/csb_pkg.sv */
package csb_pkg;
    // line driver personality, index order matches the cfg encoding
    typedef enum logic [1:0] {
        CSB_DRV_STD,
        CSB_DRV_WAND,
        CSB_DRV_WORAND
    } csb_drv_mode_t;
endpackage

/* File: core/csb_cell.sv */
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ns
`include "csb_map.svh"

module csb_cell
    import csb_pkg::*;
#(
    parameter int RAM_DEPTH = 16,
    parameter int RAM_WIDTH = 2
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic trigger_in,
    input wire logic storage_gate_enable,
    input wire logic set_or_clear_input,
    input wire logic global_init_pulse,
    input wire logic [1:0] data_in,
    output logic [1:0] q_out,
    input wire logic ram_we,
    input wire logic [3:0] ram_addr,
    input wire logic [RAM_WIDTH-1:0] ram_wdata,
    output logic [RAM_WIDTH-1:0] ram_rdata,
    input wire logic [1:0] drv_in0,
    input wire logic [1:0] drv_in1,
    input wire logic [1:0] drv_ctrl,
    output logic [1:0] line_o,
    output logic [1:0] line_oe,
    input wire logic [1:0] line_i,
    output logic [1:0] keeper_o,
    output logic [1:0] keeper_oe
);

    logic aw_have_ff, w_have_ff;
    logic [3:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic [31:0] cfg_ff, ram_init_ff;
    logic cfg_load_ff;
    logic [2:0] trig_sync_ff;
    logic [1:0] line_s1_ff, line_s2_ff;
    logic [1:0] q_ff;
    logic [RAM_WIDTH-1:0] ram_ff [RAM_DEPTH];
    logic [1:0] trig_inv, latch_mode, srval, ge_con, sr_con;
    logic [1:0] eff_now, act_edge, ge_eff, sr_eff, force_val;

    // byte lane merge used by cfg_ff and ram_init_ff; the ctrl write looks at strobe lane 0 only
    function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_known(input logic [3:0] a);
        return (a == `CSB_CFG_OFS) || (a == `CSB_RAM_INIT_OFS) ||
               (a == `CSB_CTRL_OFS) || (a == `CSB_STATUS_OFS);
    endfunction

    // write address channel: one outstanding write, released after the response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            aw_have_ff <= 1'b0;
            awaddr_ff <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            aw_have_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr[3:0];
        end else if (aw_have_ff && w_have_ff && !s_axi_bvalid) begin
            aw_have_ff <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            w_have_ff <= 1'b0;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            w_have_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
        end else if (aw_have_ff && w_have_ff && !s_axi_bvalid) begin
            w_have_ff <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    // register update and write response; upper address bits are not decoded
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff <= `CSB_CFG_RESET;
            ram_init_ff <= `CSB_RAM_INIT_RESET;
            cfg_load_ff <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CSB_RESP_OKAY;
        end else begin
            cfg_load_ff <= 1'b0;
            if (aw_have_ff && w_have_ff && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= addr_known(awaddr_ff) ? `CSB_RESP_OKAY : `CSB_RESP_SLVERR;
                if (awaddr_ff == `CSB_CFG_OFS) begin
                    cfg_ff <= merge_strb(cfg_ff, wdata_ff, wstrb_ff) & `CSB_CFG_MASK;
                end
                if (awaddr_ff == `CSB_RAM_INIT_OFS) begin
                    ram_init_ff <= merge_strb(ram_init_ff, wdata_ff, wstrb_ff);
                end
                if (awaddr_ff == `CSB_CTRL_OFS && wstrb_ff[0]) begin
                    cfg_load_ff <= wdata_ff[`CSB_CTRL_LOAD_BIT]; // self-clearing strobe
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // read channel, answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CSB_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_known(s_axi_araddr[3:0]) ? `CSB_RESP_OKAY
                                                         : `CSB_RESP_SLVERR;
            unique case (s_axi_araddr[3:0])
                `CSB_CFG_OFS: s_axi_rdata <= cfg_ff;
                `CSB_RAM_INIT_OFS: s_axi_rdata <= ram_init_ff;
                `CSB_STATUS_OFS: s_axi_rdata <= {28'h0000000, line_s2_ff, q_ff};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // config fields; gate enable deliberately has no invert bit
    assign trig_inv = cfg_ff[`CSB_CFG_INV_LSB +: 2];
    assign latch_mode = cfg_ff[`CSB_CFG_LATCH_LSB +: 2];
    assign srval = cfg_ff[`CSB_CFG_SRVAL_LSB +: 2];
    assign ge_con = cfg_ff[`CSB_CFG_GECON_LSB +: 2];
    assign sr_con = cfg_ff[`CSB_CFG_SRCON_LSB +: 2];

    // trigger comes from the fabric unsynchronised; third stage only for edges
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_sync_ff <= 3'h0;
        end else begin
            trig_sync_ff <= {trig_sync_ff[1:0], trigger_in};
        end
    end

    // per-element view of the one shared trigger pin
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            eff_now[i] = trig_sync_ff[1] ^ trig_inv[i];
            act_edge[i] = eff_now[i] & ~(trig_sync_ff[2] ^ trig_inv[i]);
            ge_eff[i] = ge_con[i] ? storage_gate_enable : 1'b1;
            sr_eff[i] = sr_con[i] & set_or_clear_input;
            force_val[i] = sr_eff[i] | global_init_pulse;
        end
    end

    // storage elements; reset value equals the default clear choice
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q_ff <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (force_val[i]) begin
                    q_ff[i] <= srval[i];
                end else if (ge_eff[i]) begin
                    if (latch_mode[i]) begin
                        if (!eff_now[i]) begin
                            q_ff[i] <= data_in[i];
                        end
                    end else if (act_edge[i]) begin
                        q_ff[i] <= data_in[i];
                    end
                end
            end
        end
    end
    assign q_out = q_ff;

    // cell ram: load only on configuration, never on the init pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int k = 0; k < RAM_DEPTH; k++) begin
                ram_ff[k] <= '0;
            end
            ram_rdata <= '0;
        end else begin
            if (cfg_load_ff) begin
                for (int k = 0; k < RAM_DEPTH; k++) begin
                    ram_ff[k] <= ram_init_ff[RAM_WIDTH*k +: RAM_WIDTH];
                end
            end else if (ram_we) begin
                ram_ff[ram_addr] <= ram_wdata;
            end
            ram_rdata <= ram_ff[ram_addr];
        end
    end

    // line drivers; bad mode code releases the line rather than contend
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_o <= 2'h0;
            line_oe <= 2'h0;
        end else begin
            for (int j = 0; j < 2; j++) begin
                unique case (csb_drv_mode_t'(cfg_ff[`CSB_CFG_DRV0_LSB + 2*j +: 2]))
                    CSB_DRV_STD: begin
                        line_o[j] <= drv_in0[j];
                        line_oe[j] <= ~drv_ctrl[j];
                    end
                    CSB_DRV_WAND: begin
                        line_o[j] <= 1'b0;
                        line_oe[j] <= ~drv_in0[j];
                    end
                    CSB_DRV_WORAND: begin
                        line_o[j] <= 1'b0;
                        line_oe[j] <= ~(drv_in0[j] | drv_in1[j]);
                    end
                    default: begin
                        line_o[j] <= 1'b0;
                        line_oe[j] <= 1'b0;
                    end
                endcase
            end
        end
    end

    // keeper: weak drive of last seen level, resolved below any driver
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            line_s1_ff <= 2'h0;
            line_s2_ff <= 2'h0;
            keeper_o <= 2'h0;
            keeper_oe <= 2'h0;
        end else begin
            line_s1_ff <= line_i;
            line_s2_ff <= line_s1_ff;
            keeper_o <= line_s2_ff;
            keeper_oe <= 2'h3;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_FORCE_VALUE: assert property (
        force_val[0] |=> q_ff[0] == $past(srval[0]))
        else $error("forced element did not take set/clear value");
    AST_FF_LOAD: assert property (
        !latch_mode[0] && !force_val[0] && ge_eff[0] && act_edge[0]
        |=> q_ff[0] == $past(data_in[0]))
        else $error("flip-flop missed data on active edge");
    AST_FF_HOLD: assert property (
        !latch_mode[0] && !force_val[0] && !act_edge[0] |=> $stable(q_ff[0]))
        else $error("flip-flop changed without active edge");
    AST_GATE_LOW: assert property (
        ge_con[1] && !storage_gate_enable && !force_val[1] |=> $stable(q_ff[1]))
        else $error("element changed while gate enable low");
    AST_LATCH_PASS: assert property (
        latch_mode[1] && !force_val[1] && ge_eff[1] && !eff_now[1]
        |=> q_ff[1] == $past(data_in[1]))
        else $error("latch not transparent while trigger low");
    AST_LATCH_HOLD: assert property (
        latch_mode[1] && !force_val[1] && eff_now[1] |=> $stable(q_ff[1]))
        else $error("latch changed while trigger high");
    AST_SR_UNCONN: assert property (
        !sr_con[0] && !global_init_pulse && set_or_clear_input && ge_eff[0]
        && !latch_mode[0] && act_edge[0] |=> q_ff[0] == $past(data_in[0]))
        else $error("unconnected set/clear still acted");
    AST_RAM_INIT_KEEP: assert property (
        global_init_pulse && !cfg_load_ff && !ram_we |=> ram_ff[0] == $past(ram_ff[0]))
        else $error("init pulse disturbed ram");
    AST_RAM_LOAD: assert property (
        cfg_load_ff |=> ram_ff[1] == $past(ram_init_ff[3:2]))
        else $error("configuration did not load ram");
    AST_STD_RELEASE: assert property (
        cfg_ff[`CSB_CFG_DRV0_LSB +: 2] == 2'h0 && drv_ctrl[0] |=> !line_oe[0])
        else $error("standard driver drove with control high");
    AST_WAND_DRIVE: assert property (
        cfg_ff[`CSB_CFG_DRV0_LSB +: 2] == 2'h1 |=> !line_o[0]
        && line_oe[0] == !$past(drv_in0[0]))
        else $error("wired-and driver did not follow input");
    AST_WORAND_DRIVE: assert property (
        cfg_ff[`CSB_CFG_DRV1_LSB +: 2] == 2'h2 && (drv_in0[1] || drv_in1[1]) |=> !line_oe[1])
        else $error("or-and driver did not release");

    COV_FF_LOAD: cover property (!latch_mode[0] && act_edge[0] && ge_eff[0] && data_in[0]);
    COV_LATCH_PASS: cover property (latch_mode[1] && !eff_now[1] && ge_eff[1]);
    COV_RAM_LOAD: cover property (cfg_load_ff ##1 global_init_pulse);

endmodule

/* File: sim/csb_line_model.sv */
`timescale 1ns/1ns

// far-side fabric: pull-ups, a foreign driver and the wire itself
module csb_line_model (
    input wire logic aclk,
    input wire logic [1:0] line_o,
    input wire logic [1:0] line_oe,
    input wire logic [1:0] keeper_o,
    input wire logic [1:0] keeper_oe,
    input wire logic [1:0] pullup_en,
    input wire logic [1:0] ext_oe,
    input wire logic [1:0] ext_val,
    output logic [1:0] line_i
);
    logic float_ff = 1'h0;

    // a floating line toggles, so a stale level never passes by luck
    always_ff @(posedge aclk) begin
        float_ff <= ~float_ff;
    end

    // foreign driver backs off while the cell drives
    // keeper ranks below every driver and the pull-up
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (line_oe[i]) line_i[i] = line_o[i];
            else if (ext_oe[i]) line_i[i] = ext_val[i];
            else if (pullup_en[i]) line_i[i] = 1'h1;
            else if (keeper_oe[i]) line_i[i] = keeper_o[i];
            else line_i[i] = float_ff;
        end
    end
endmodule

/* File: sim/csb_cell_tb.sv */
`timescale 1ns/1ns
`include "csb_map.svh"

module csb_cell_tb;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb = 4'hf, ram_addr = '0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs, q_out, ram_rdata, line_o, line_oe, line_i;
    logic trigger_in = 1'h0, storage_gate_enable = 1'h0, set_or_clear_input = 1'h0;
    logic global_init_pulse = 1'h0, ram_we = 1'h0;
    logic [1:0] data_in = '0, ram_wdata = '0, drv_in0 = '0, drv_in1 = '0, drv_ctrl = 2'h3;
    logic [1:0] keeper_o, keeper_oe, pu = 2'h3, ext_oe = '0, ext_val = '0;
    int miscompares = 0, compares = 0, cyc = 0;

    csb_cell DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trigger_in,
        .storage_gate_enable, .set_or_clear_input, .global_init_pulse, .data_in, .q_out,
        .ram_we, .ram_addr, .ram_wdata, .ram_rdata, .drv_in0, .drv_in1, .drv_ctrl,
        .line_o, .line_oe, .line_i, .keeper_o, .keeper_oe);

    csb_line_model far_side (.aclk, .line_o, .line_oe, .keeper_o, .keeper_oe,
        .pullup_en(pu), .ext_oe, .ext_val, .line_i);

    // 100 MHz clock
    initial begin
        forever #5 aclk = ~aclk;
    end

    // hang guard, well above the expected run length
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge aclk);
    endtask

    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        rs = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk); // idle edge, so a following call never redrives bready in one step
    endtask

    task automatic rdr(input logic [31:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk); // idle edge, so a following call never redrives rready in one step
    endtask

    // registered ram read, one cycle behind the address
    task automatic ramrd(input logic [3:0] k);
        ram_addr <= k;
        tick(2);
    endtask

    function automatic logic [1:0] exp_q(logic [9:0] c, logic sc, logic ge, logic r,
                                         logic [1:0] d, logic [1:0] q0);
        for (int i = 0; i < 2; i++) begin
            if (c[8+i] && sc) exp_q[i] = c[4+i];
            else if (c[6+i] && !ge) exp_q[i] = q0[i];
            else if (r != c[i]) exp_q[i] = d[i];
            else exp_q[i] = q0[i];
        end
    endfunction

    // wired modes only ever pull low; mode 3 stays off the line
    function automatic logic [1:0] exp_oe(int m, logic [1:0] a, logic [1:0] b, logic [1:0] t);
        case (m)
            0: return ~t;
            1: return ~a;
            2: return ~(a | b);
            default: return 2'h0;
        endcase
    endfunction

    initial begin
        logic [9:0] c;
        logic [1:0] d, q0, eo, ee;
        logic sc, ge, r;
        logic [31:0] v;
        void'($urandom(9147));
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        // reset state, register map and a misaligned offset
        chk(q_out, 2'h0);
        rdr(`CSB_CFG_OFS);
        chk(rd, `CSB_CFG_RESET);
        wr(`CSB_CFG_OFS, 32'hffff_ffff);
        rdr(`CSB_CFG_OFS);
        chk(rd, `CSB_CFG_MASK);
        wr(32'h1, 32'h0);
        chk(rs, `CSB_RESP_SLVERR);
        rdr(32'h1);
        chk(rd, 32'h0);
        chk(rs, `CSB_RESP_SLVERR);
        $display("test regs done");
        // random flip-flop traffic: polarity, enable, set/clear per element
        for (int i = 0; i < 40; i++) begin
            c = 10'($urandom) & 10'h3f3;
            r = 1'($urandom);
            trigger_in <= ~r;
            wr(`CSB_CFG_OFS, {22'h0, c});
            sc = 1'($urandom);
            ge = 1'($urandom);
            d = 2'($urandom);
            set_or_clear_input <= sc;
            storage_gate_enable <= ge;
            data_in <= d;
            tick(6);
            q0 = q_out;
            trigger_in <= r;
            tick(6);
            chk(q_out, exp_q(c, sc, ge, r, d, q0));
        end
        rdr(`CSB_STATUS_OFS);
        chk(rd[1:0], exp_q(c, sc, ge, r, d, q0));
        $display("test flipflop done");
        // latch: open while trigger low, closed while high
        wr(`CSB_CFG_OFS, 32'h0c);
        for (int i = 0; i < 4; i++) begin
            d = 2'($urandom);
            trigger_in <= 1'h0;
            data_in <= d;
            tick(6);
            chk(q_out, d);
            trigger_in <= 1'h1;
            tick(6);
            data_in <= ~d;
            tick(6);
            chk(q_out, d);
        end
        $display("test latch done");
        // unconnected set/clear ignored, init pulse forces set value
        wr(`CSB_CFG_OFS, 32'h20);
        trigger_in <= 1'h0;
        data_in <= 2'h1;
        tick(4);
        trigger_in <= 1'h1;
        set_or_clear_input <= 1'h1;
        tick(6);
        chk(q_out, 2'h1);
        wr(`CSB_CFG_OFS, 32'h320);
        tick(6);
        chk(q_out, 2'h2);
        wr(`CSB_CFG_OFS, 32'h20);
        set_or_clear_input <= 1'h0;
        data_in <= 2'h0;
        trigger_in <= 1'h0;
        tick(4);
        trigger_in <= 1'h1;
        tick(6);
        global_init_pulse <= 1'h1;
        tick(1);
        global_init_pulse <= 1'h0;
        tick(4);
        chk(q_out, 2'h2);
        $display("test set clear done");
        // ram: zero by default, loaded by configuration, kept by init pulse
        for (int k = 0; k < 16; k++) begin
            ramrd(4'(k));
            chk(ram_rdata, 2'h0);
        end
        v = $urandom;
        wr(`CSB_RAM_INIT_OFS, v);
        wr(`CSB_CTRL_OFS, 32'h1);
        tick(4);
        for (int k = 0; k < 16; k++) begin
            ramrd(4'(k));
            chk(ram_rdata, v[2*k+:2]);
        end
        ram_addr <= 4'h5;
        ram_wdata <= ~v[11:10];
        ram_we <= 1'h1;
        tick(1);
        ram_we <= 1'h0;
        global_init_pulse <= 1'h1;
        tick(1);
        global_init_pulse <= 1'h0;
        tick(4);
        ramrd(4'h5);
        chk(ram_rdata, 2'(~v[11:10]));
        $display("test ram done");
        // every driver mode against every input pattern, pull-ups on
        for (int m = 0; m < 4; m++) begin
            wr(`CSB_CFG_OFS, (m << 10) | (m << 12));
            for (int i = 0; i < 8; i++) begin
                drv_in0 <= {~i[0], i[0]};
                drv_in1 <= {~i[1], i[1]};
                drv_ctrl <= {~i[2], i[2]};
                tick(3);
                ee = exp_oe(m, drv_in0, drv_in1, drv_ctrl);
                eo = (m == 0) ? drv_in0 : 2'h0;
                chk(line_oe, ee);
                chk(line_o & ee, eo & ee);
                tick(4);
                rdr(`CSB_STATUS_OFS);
                chk(rd[3:2], 2'((eo & ee) | ~ee));
            end
        end
        $display("test drivers done");
        // keeper holds the last level once every driver lets go
        pu <= 2'h0;
        wr(`CSB_CFG_OFS, 32'h3c00);
        ext_val <= 2'h2;
        ext_oe <= 2'h3;
        tick(6);
        ext_oe <= 2'h0;
        tick(6);
        rdr(`CSB_STATUS_OFS);
        chk(rd[3:2], 2'h2);
        wr(`CSB_CFG_OFS, 32'h0);
        drv_in0 <= 2'h1;
        drv_ctrl <= 2'h0;
        tick(6);
        drv_ctrl <= 2'h3;
        tick(6);
        rdr(`CSB_STATUS_OFS);
        chk(rd[3:2], 2'h1);
        $display("test keeper done");
        give_verdict();
    end
endmodule
